// file: rmsaux_pkg.sv
package rmsaux_pkg;
  // register indices on the write/read port
  localparam logic [3:0] REG_VOLTAGE_GAIN = 4'h0;
  localparam logic [3:0] REG_CURRENT_GAIN = 4'h1;
  localparam logic [3:0] REG_PHASE_COMP = 4'h2;
  localparam logic [3:0] REG_LOWPASS = 4'h3;
  localparam logic [3:0] REG_DSP_CONFIG = 4'h4;
  localparam logic [3:0] REG_CURRENT_OFFSET = 4'h5;
  localparam logic [3:0] REG_CURRENT_V_OFFSET = 4'h6;
  localparam logic [3:0] REG_CURRENT_V_GAIN = 4'h7;
  localparam logic [3:0] REG_CURRENT_INVERSE = 4'h8;
  localparam logic [3:0] REG_POWER_OFFSET = 4'h9;
  localparam logic [3:0] REG_POWER_GAIN = 4'ha;
  localparam int unsigned REG_COUNT = 11;
  // reset values and fields
  localparam logic [15:0] TRIM_RESET = 16'h0000;
  localparam logic [15:0] LOWPASS_RESET = 16'h004b;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam int unsigned CFG_PWM_BIT = 6;
  // serial frame timing, in system clocks
  localparam int unsigned BIT_CYCLES = 2000;
  localparam int unsigned SLICE_CYCLES = BIT_CYCLES / 4;
  localparam int unsigned ZERO_HIGH = SLICE_CYCLES;
  localparam int unsigned ONE_HIGH = 3 * SLICE_CYCLES;
  localparam int unsigned WORD_BITS = 20;
  localparam int unsigned GAP_BITS = 4;
  localparam logic [3:0] SYNC_NIBBLE = 4'hc;
  localparam int unsigned GAIN_SHIFT = 16;

  typedef enum logic [1:0] {
    ST_WORD = 2'b00,
    ST_GAP = 2'b01,
    ST_PWM = 2'b10
  } rmsaux_state_t;

  // register write strobe with index and data
  typedef struct packed {
    logic en;
    logic [3:0] sel;
    logic [15:0] data;
  } rmsaux_wr_t;

  // raw meter-unit measurements
  typedef struct packed {
    logic [15:0] voltage;
    logic [15:0] current;
    logic [15:0] power;
  } rmsaux_raw_t;

  // corrected results
  typedef struct packed {
    logic [15:0] voltage_rms_value;
    logic [15:0] current_rms_value;
    logic [15:0] active;
    logic [31:0] apparent;
    logic [31:0] reactive;
  } rmsaux_meas_t;
endpackage

// file: rmsaux_rx_model.sv
// remote receiver: decodes the pulse-width-coded current stream on the aux line
module rmsaux_rx_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic line,
  output logic [19:0] rx_word,
  output logic [7:0] frame_cnt,
  output logic [7:0] bad_cnt,
  output logic [7:0] gap_cnt,
  output logic [15:0] gap_len
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev;
  logic locked;
  logic bit_val;
  logic [15:0] span;
  logic [15:0] high_len;
  logic [4:0] nbits;
  logic [19:0] shift;

  ////////////////////////////////////////////////////////////////////////////////
  // edge timing and bit decode; widths off 500/1500 or cells under 2000 count as bad, longer cells are gaps
  always @(posedge clk) begin
    if (rst) begin
      prev <= 1'b0;
      locked <= 1'b0;
      span <= 16'h0000;
      high_len <= 16'h0000;
      nbits <= 5'h00;
      shift <= 20'h00000;
      rx_word <= 20'h00000;
      frame_cnt <= 8'h00;
      bad_cnt <= 8'h00;
      gap_cnt <= 8'h00;
      gap_len <= 16'h0000;
    end else begin
      prev <= line;
      span <= span + 16'h0001;
      if (line) high_len <= high_len + 16'h0001;
      if (line && !prev) begin
        span <= 16'h0001;
        high_len <= 16'h0001;
        if (!locked || span > 16'(rmsaux_pkg::BIT_CYCLES)) begin
          if (locked) begin
            gap_len <= span;
            gap_cnt <= gap_cnt + 8'h01;
          end
          locked <= 1'b1;
          nbits <= 5'h00;
        end else if (span != 16'(rmsaux_pkg::BIT_CYCLES)) begin
          bad_cnt <= bad_cnt + 8'h01;
        end
      end
      // long pulse is a one; the decision point sits halfway between the two widths
      if (!line && prev && locked) begin
        bit_val = high_len > 16'(rmsaux_pkg::BIT_CYCLES / 2);
        if (high_len != 16'(rmsaux_pkg::ZERO_HIGH) && high_len != 16'(rmsaux_pkg::ONE_HIGH))
          bad_cnt <= bad_cnt + 8'h01;
        shift <= {shift[18:0], bit_val};
        nbits <= nbits + 5'h01;
        if (nbits == 5'd19) begin
          rx_word <= {shift[18:0], bit_val};
          frame_cnt <= frame_cnt + 8'h01;
        end
      end
    end
  end
endmodule // rmsaux_rx_model

// file: rmsaux_top.sv
// How it works
// - serial mode sends corrected current as 16 bits, forever
// - each bit cell lasts 2000 clocks
// - cell split in four slices, line rises at cell start
// - zero bit: high for one slice
// - frame word is sync 1100 then current bits msb first
// - four low bit cells of gap after data, then next sync
// - config bit 6 selects continuous pwm on the aux pin
// - pwm select resets to zero, serial output by default
// - pwm period is 65535 clocks
// - voltage scaled by one plus signed trim over 65536, trim resets zero
// - current scaled by one plus signed trim over 65536, also in power
// - current is offset, v offset term, gain term times raw, k over raw
// - power = voltage, current, power gains times offset plus raw power
// - apparent power is corrected voltage times corrected current
// - reactive power is sqrt of apparent squared minus active squared
// - lowpass coefficient is only stored and read back, resets to 75
module rmsaux_top #(
  parameter int unsigned PWM_PERIOD = 65535
) (
  input wire logic clk,
  input wire logic rst,
  input wire rmsaux_pkg::rmsaux_wr_t reg_wr,
  input wire logic [3:0] rd_sel,
  input wire logic sample_valid,
  input wire rmsaux_pkg::rmsaux_raw_t raw,
  output logic [15:0] rd_data,
  output rmsaux_pkg::rmsaux_meas_t meas,
  output logic aux_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] sat_u16(input logic signed [47:0] x);
    if (x < 0) return 16'h0000;
    if (x > 48'sh00000000ffff) return 16'hffff;
    return x[15:0];
  endfunction

  // x * (1 + g / 65536), g signed
  function automatic logic signed [47:0] trim_scale(input logic signed [47:0] x,
                                                    input logic [15:0] g);
    logic signed [47:0] gs;
    gs = 48'($signed(g));
    return x + ((x * gs) >>> rmsaux_pkg::GAIN_SHIFT);
  endfunction

  function automatic logic [31:0] isqrt(input logic [63:0] x);
    logic [31:0] r;
    logic [31:0] t;
    r = 32'h0;
    for (int i = 31; i >= 0; i--) begin
      t = r | (32'h1 << i);
      if ({32'h0, t} * {32'h0, t} <= x) r = t;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [15:0] regs_reg [rmsaux_pkg::REG_COUNT];
  logic [15:0] regs_next [rmsaux_pkg::REG_COUNT];
  logic [15:0] rd_data_next;
  logic pwm_sel;

  // one indexed write per cycle; unmapped indices are dropped, read as zero
  always_comb begin
    regs_next = regs_reg;
    if (reg_wr.en && (32'(reg_wr.sel) < rmsaux_pkg::REG_COUNT)) begin
      regs_next[reg_wr.sel] = reg_wr.data;
    end
    rd_data_next = 16'h0000;
    if (32'(rd_sel) < rmsaux_pkg::REG_COUNT) begin
      rd_data_next = regs_reg[rd_sel];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < rmsaux_pkg::REG_COUNT; i++) begin
        regs_reg[i] <= rmsaux_pkg::TRIM_RESET;
      end
      regs_reg[rmsaux_pkg::REG_LOWPASS] <= rmsaux_pkg::LOWPASS_RESET;
      regs_reg[rmsaux_pkg::REG_DSP_CONFIG] <= rmsaux_pkg::CONFIG_RESET;
      rd_data <= 16'h0000;
    end else begin
      regs_reg <= regs_next;
      rd_data <= rd_data_next;
    end
  end

  assign pwm_sel = regs_reg[rmsaux_pkg::REG_DSP_CONFIG][rmsaux_pkg::CFG_PWM_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // calibration arithmetic, one result set per sample strobe
  rmsaux_pkg::rmsaux_meas_t meas_next;
  logic signed [47:0] v_corr;
  logic signed [47:0] g_eff;
  logic signed [47:0] i_corr;
  logic signed [47:0] p_corr;
  logic [15:0] inv_term;
  logic [63:0] s_sq;
  logic [63:0] p_sq;

  // long combinational path; results only needed at the sample rate
  always_comb begin
    meas_next = meas;
    v_corr = trim_scale(48'(raw.voltage), regs_reg[rmsaux_pkg::REG_VOLTAGE_GAIN]);
    meas_next.voltage_rms_value = sat_u16(v_corr);
    // gain plus voltage-dependent gain
    // unsigned operands made signed, else the whole sum turns unsigned and >>> goes logical
    g_eff = 48'($signed(regs_reg[rmsaux_pkg::REG_CURRENT_GAIN]))
      + ((48'($signed(regs_reg[rmsaux_pkg::REG_CURRENT_V_GAIN]))
      * $signed(48'(meas_next.voltage_rms_value))) >>> rmsaux_pkg::GAIN_SHIFT);
    // divide by zero guarded: inverse term drops out at zero current
    inv_term = (raw.current != 16'h0000)
      ? regs_reg[rmsaux_pkg::REG_CURRENT_INVERSE] / raw.current : 16'h0000;
    // current gain applied as 1 + g / 65536
    // offset, voltage offset, gain and inverse terms summed
    i_corr = 48'($signed(regs_reg[rmsaux_pkg::REG_CURRENT_OFFSET]))
      + ((48'($signed(regs_reg[rmsaux_pkg::REG_CURRENT_V_OFFSET]))
      * $signed(48'(meas_next.voltage_rms_value))) >>> rmsaux_pkg::GAIN_SHIFT)
      + $signed(48'(raw.current))
      + (($signed(48'(raw.current)) * g_eff) >>> rmsaux_pkg::GAIN_SHIFT)
      + $signed(48'(inv_term));
    meas_next.current_rms_value = sat_u16(i_corr);
    // three gain factors on offset plus raw power
    p_corr = 48'($signed(regs_reg[rmsaux_pkg::REG_POWER_OFFSET])) + 48'(raw.power);
    p_corr = trim_scale(p_corr, regs_reg[rmsaux_pkg::REG_VOLTAGE_GAIN]);
    p_corr = trim_scale(p_corr, regs_reg[rmsaux_pkg::REG_CURRENT_GAIN]);
    p_corr = trim_scale(p_corr, regs_reg[rmsaux_pkg::REG_POWER_GAIN]);
    meas_next.active = sat_u16(p_corr);
    meas_next.apparent = meas_next.voltage_rms_value * meas_next.current_rms_value;
    // reactive power, clamped at zero if active exceeds apparent
    s_sq = {32'h0, meas_next.apparent} * {32'h0, meas_next.apparent};
    p_sq = {48'h0, meas_next.active} * {48'h0, meas_next.active};
    meas_next.reactive = (s_sq > p_sq) ? isqrt(s_sq - p_sq) : 32'h0;
    if (!sample_valid) meas_next = meas;
  end

  // results register
  always_ff @(posedge clk) begin
    if (rst) meas <= '0;
    else meas <= meas_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // aux pin transmitter
  // local names for the package's state codes
  localparam rmsaux_pkg::rmsaux_state_t ST_WORD = rmsaux_pkg::ST_WORD;
  localparam rmsaux_pkg::rmsaux_state_t ST_GAP = rmsaux_pkg::ST_GAP;
  localparam rmsaux_pkg::rmsaux_state_t ST_PWM = rmsaux_pkg::ST_PWM;
  rmsaux_pkg::rmsaux_state_t state_reg, state_next;
  logic [10:0] cell_reg, cell_next;
  logic [4:0] idx_reg, idx_next;
  logic [19:0] word_reg, word_next;
  logic [15:0] pwm_cnt_reg, pwm_cnt_next;
  logic aux_next;
  logic cell_end;

  assign cell_end = (32'(cell_reg) == rmsaux_pkg::BIT_CYCLES - 1);

  // counters first, then the line level from the new counters so that
  // the pin and the counters stay aligned cycle for cycle
  always_comb begin
    state_next = state_reg;
    cell_next = cell_end ? 11'h000 : cell_reg + 11'h001;
    idx_next = idx_reg;
    word_next = word_reg;
    pwm_cnt_next = 16'h0000;
    aux_next = 1'b0;
    case (state_reg)
      ST_WORD: begin
        if (cell_end) begin
          // gap after the last data bit
          if (32'(idx_reg) == rmsaux_pkg::WORD_BITS - 1) begin
            state_next = ST_GAP;
            idx_next = 5'h00;
          end else begin
            idx_next = idx_reg + 5'h01;
          end
        end
      end
      ST_GAP: begin
        if (cell_end) begin
          idx_next = idx_reg + 5'h01;
          // restart with a fresh current sample
          // sync nibble above the current bits
          if (32'(idx_reg) == rmsaux_pkg::GAP_BITS - 1) begin
            state_next = ST_WORD;
            idx_next = 5'h00;
            word_next = {rmsaux_pkg::SYNC_NIBBLE, meas.current_rms_value};
          end
        end
      end
      ST_PWM: begin
        pwm_cnt_next = (32'(pwm_cnt_reg) >= PWM_PERIOD - 1) ? 16'h0000
          : pwm_cnt_reg + 16'h0001;
        cell_next = 11'h000;
      end
      default: state_next = ST_GAP;
    endcase
    // mode select; leaving pwm passes through a full gap
    if (pwm_sel && state_reg != ST_PWM) begin
      state_next = ST_PWM;
      pwm_cnt_next = 16'h0000;
    end else if (!pwm_sel && state_reg == ST_PWM) begin
      state_next = ST_GAP;
      cell_next = 11'h000;
      idx_next = 5'h00;
    end
    // rise at slice one, zero ends after one slice
    if (state_next == ST_WORD) begin
      aux_next = word_next[5'(rmsaux_pkg::WORD_BITS - 1) - idx_next]
        ? (32'(cell_next) < rmsaux_pkg::ONE_HIGH)
        : (32'(cell_next) < rmsaux_pkg::ZERO_HIGH);
    end else if (state_next == ST_PWM) begin
      // duty follows current, full scale is always high
      aux_next = (pwm_cnt_next < meas.current_rms_value);
    end
  end

  // transmitter registers; starts with a gap so the first frame is whole
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_GAP;
      cell_reg <= 11'h000;
      idx_reg <= 5'h00;
      word_reg <= 20'h00000;
      pwm_cnt_reg <= 16'h0000;
      aux_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      cell_reg <= cell_next;
      idx_reg <= idx_next;
      word_reg <= word_next;
      pwm_cnt_reg <= pwm_cnt_next;
      aux_out <= aux_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [11:0] high_len_reg;

  // length of the current high run of the pin
  always_ff @(posedge clk) begin
    if (rst) high_len_reg <= 12'h000;
    else high_len_reg <= aux_out ? high_len_reg + 12'h001 : 12'h000;
  end

  // cycles since the pin last rose, saturating; a rise is high after a low sample
  logic [11:0] rise_dist_reg;
  always_ff @(posedge clk) begin
    if (rst) rise_dist_reg <= 12'h000;
    else if (aux_out && high_len_reg == 12'h000) rise_dist_reg <= 12'h001;
    else if (rise_dist_reg != 12'hfff) rise_dist_reg <= rise_dist_reg + 12'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_pwm_reset: assert property ($fell(rst) |-> !pwm_sel)
    else $error("pwm select not clear after reset");
  a_high_width: assert property (
    $fell(aux_out) && state_reg != ST_PWM && $past(state_reg) != ST_PWM
    |-> (high_len_reg == 12'(rmsaux_pkg::ZERO_HIGH)
    || high_len_reg == 12'(rmsaux_pkg::ONE_HIGH)))
    else $error("serial high pulse has wrong width");
  a_cell_rise: assert property (
    $rose(aux_out) && state_reg != ST_PWM |-> state_reg == ST_WORD && cell_reg == 11'h000)
    else $error("serial rise not at cell start");
  a_gap_low: assert property (state_reg == ST_GAP |-> !aux_out)
    else $error("line not low during frame gap");
  a_gap_end: assert property (
    state_reg == ST_GAP && idx_reg == 5'(rmsaux_pkg::GAP_BITS - 1) && cell_end && !pwm_sel
    |=> state_reg == ST_WORD && aux_out ##1 aux_out)
    else $error("sync did not follow gap");
  a_sync_nibble: assert property (
    state_reg == ST_WORD && idx_reg < 5'h04 && cell_reg == 11'(rmsaux_pkg::ZERO_HIGH)
    |-> aux_out == (idx_reg < 5'h02))
    else $error("sync nibble pattern wrong");
  a_data_bits: assert property (
    state_reg == ST_WORD && idx_reg >= 5'h04 && cell_reg == 11'(rmsaux_pkg::ZERO_HIGH)
    |-> aux_out == word_reg[5'(rmsaux_pkg::WORD_BITS - 1) - idx_reg])
    else $error("data bit level wrong");
  a_cell_length: assert property (
    $rose(aux_out) && state_reg == ST_WORD && idx_reg != 5'h00
    |-> rise_dist_reg == 12'(rmsaux_pkg::BIT_CYCLES))
    else $error("bit cell length wrong");
  a_pwm_enter: assert property ($rose(pwm_sel) |=> state_reg == ST_PWM)
    else $error("pwm mode not entered");
  a_pwm_wrap: assert property (
    state_reg == ST_PWM && pwm_sel && 32'(pwm_cnt_reg) == PWM_PERIOD - 1
    |=> pwm_cnt_reg == 16'h0000)
    else $error("pwm period wrong");
  a_voltage_rms_value_unity: assert property (
    sample_valid && regs_reg[rmsaux_pkg::REG_VOLTAGE_GAIN] == 16'h0000
    |=> meas.voltage_rms_value == $past(raw.voltage))
    else $error("unity voltage gain altered value");
  a_current_rms_value_unity: assert property (
    sample_valid && regs_reg[rmsaux_pkg::REG_CURRENT_GAIN] == 16'h0000
    && regs_reg[rmsaux_pkg::REG_CURRENT_OFFSET] == 16'h0000
    && regs_reg[rmsaux_pkg::REG_CURRENT_V_OFFSET] == 16'h0000
    && regs_reg[rmsaux_pkg::REG_CURRENT_V_GAIN] == 16'h0000
    && regs_reg[rmsaux_pkg::REG_CURRENT_INVERSE] == 16'h0000
    |=> meas.current_rms_value == $past(raw.current))
    else $error("unity current correction altered value");
  a_apparent: assert property (
    $past(sample_valid) |-> meas.apparent == meas.voltage_rms_value * meas.current_rms_value)
    else $error("apparent power mismatch");

  c_frame_start: cover property (state_reg == ST_GAP ##1 state_reg == ST_WORD);
  c_pwm_run: cover property (state_reg == ST_PWM && aux_out ##1 !aux_out);
  c_back_serial: cover property (state_reg == ST_PWM ##1 state_reg == ST_GAP);

endmodule // rmsaux_top

// file: tb_rms_current_aux_output.sv
module tb_rms_current_aux_output;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [15:0] v, i, p, ev, ei, ep;
    logic [31:0] es, eq;
  } rmsaux_row_t;
  logic clk, rst, sample_valid, aux_out;
  logic [3:0] rd_sel;
  logic [15:0] rd_data;
  rmsaux_pkg::rmsaux_wr_t reg_wr;
  rmsaux_pkg::rmsaux_raw_t raw;
  rmsaux_pkg::rmsaux_meas_t meas;
  logic [19:0] rx_word;
  logic [7:0] frame_cnt, bad_cnt, gap_cnt;
  logic [15:0] gap_len;
  rmsaux_row_t rows [4];
  int err_count = 0;
  int n_tests = 0;
  int hi, rises;
  logic last;

  rmsaux_top #(.PWM_PERIOD(16)) dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .rd_sel(rd_sel),
    .sample_valid(sample_valid), .raw(raw), .rd_data(rd_data), .meas(meas), .aux_out(aux_out));
  rmsaux_rx_model rx (.clk(clk), .rst(rst), .line(aux_out), .rx_word(rx_word),
    .frame_cnt(frame_cnt), .bad_cnt(bad_cnt), .gap_cnt(gap_cnt), .gap_len(gap_len));

  // 40 mhz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task wrap_up;
    $display("checks %0d, errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // strobe high one cycle, then low at least one cycle before the next write
  task wr(input logic [3:0] s, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= '{en: 1'b1, sel: s, data: d};
    @(posedge clk);
    reg_wr.en <= 1'b0;
  endtask

  task rd(input logic [3:0] s, input logic [15:0] e);
    @(posedge clk);
    rd_sel <= s;
    repeat (2) @(posedge clk);
    #1;
    check({16'h0000, rd_data}, {16'h0000, e}, "register read");
  endtask

  task samp(input logic [15:0] v, input logic [15:0] i, input logic [15:0] p);
    @(posedge clk);
    sample_valid <= 1'b1;
    raw <= '{voltage: v, current: i, power: p};
    @(posedge clk);
    sample_valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  // hang guard: the whole run needs about 60000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    wrap_up;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    reg_wr = '0;
    rd_sel = 4'h0;
    sample_valid = 1'b0;
    raw = '0;
    rows = '{'{16'h0005, 16'h0005, 16'h000f, 16'h0005, 16'h0005, 16'h000f, 32'h19, 32'h14},
      '{16'h0100, 16'h0100, 16'h0000, 16'h0100, 16'h0100, 16'h0000, 32'h10000, 32'h10000},
      '{16'h0002, 16'h0002, 16'h0009, 16'h0002, 16'h0002, 16'h0009, 32'h4, 32'h0},
      '{16'h0007, 16'h0000, 16'h0000, 16'h0007, 16'h0000, 16'h0000, 32'h0, 32'h0}};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // reset values, unmapped indices read zero
    for (int k = 0; k < 16; k++)
      rd(k[3:0], k == 3 ? rmsaux_pkg::LOWPASS_RESET : rmsaux_pkg::TRIM_RESET);
    // ordinary measurements with all trims at zero
    for (int k = 0; k < 4; k++) begin
      samp(rows[k].v, rows[k].i, rows[k].p);
      check({16'h0, meas.voltage_rms_value}, {16'h0, rows[k].ev}, "voltage");
      check({16'h0, meas.current_rms_value}, {16'h0, rows[k].ei}, "current");
      check({16'h0, meas.active}, {16'h0, rows[k].ep}, "active");
      check(meas.apparent, rows[k].es, "apparent");
      check(meas.reactive, rows[k].eq, "reactive");
    end
    // offset, inverse and power offset terms; voltage zero keeps v terms out
    wr(rmsaux_pkg::REG_CURRENT_OFFSET, 16'h0010);
    wr(rmsaux_pkg::REG_CURRENT_INVERSE, 16'h0064);
    wr(rmsaux_pkg::REG_POWER_OFFSET, 16'h000a);
    samp(16'h0000, 16'h0005, 16'h000f);
    check({16'h0, meas.current_rms_value}, 32'h29, "current terms");
    check({16'h0, meas.active}, 32'h19, "power offset");
    wr(rmsaux_pkg::REG_CURRENT_OFFSET, 16'h0000);
    wr(rmsaux_pkg::REG_CURRENT_INVERSE, 16'h0000);
    wr(rmsaux_pkg::REG_POWER_OFFSET, 16'h0000);
    // signed gain trims: +0.25 on voltage, -0.5 on current
    wr(rmsaux_pkg::REG_VOLTAGE_GAIN, 16'h4000);
    wr(rmsaux_pkg::REG_CURRENT_GAIN, 16'h8000);
    rd(rmsaux_pkg::REG_CURRENT_GAIN, 16'h8000);
    samp(16'h1000, 16'h1234, 16'h0000);
    check({16'h0, meas.voltage_rms_value}, 32'h1400, "voltage trim");
    check({16'h0, meas.current_rms_value}, 32'h091a, "current trim");
    check(meas.apparent, 32'h00b60800, "trimmed apparent");
    check(meas.reactive, 32'h00b60800, "trimmed reactive");
    // first frame after the reset gap carries the trimmed current
    for (int n = 0; n < 60000 && frame_cnt !== 8'h01; n++) @(posedge clk);
    check({12'h0, rx_word}, {12'h0, rmsaux_pkg::SYNC_NIBBLE, 16'h091a}, "frame");
    check({24'h0, bad_cnt}, 32'h0, "cell timing");
    for (int n = 0; n < 12000 && gap_cnt !== 8'h01; n++) @(posedge clk);
    check({16'h0, gap_len}, (rmsaux_pkg::GAP_BITS + 1) * rmsaux_pkg::BIT_CYCLES, "gap");
    // pwm with period 16 and current 5: 20 high cycles and 4 rises in 64
    wr(rmsaux_pkg::REG_CURRENT_GAIN, 16'h0000);
    wr(rmsaux_pkg::REG_VOLTAGE_GAIN, 16'h0000);
    // voltage-dependent current terms at half-scale voltage, power gain +0.25
    wr(rmsaux_pkg::REG_CURRENT_V_OFFSET, 16'h0010);
    wr(rmsaux_pkg::REG_CURRENT_V_GAIN, 16'h2000);
    wr(rmsaux_pkg::REG_POWER_GAIN, 16'h4000);
    samp(16'h8000, 16'h0100, 16'h0100);
    check({16'h0, meas.current_rms_value}, 32'h0118, "voltage terms");
    check({16'h0, meas.active}, 32'h0140, "power gain");
    check(meas.apparent, 32'h008c0000, "apparent with terms");
    check(meas.reactive, 32'h008bffff, "reactive floor");
    wr(rmsaux_pkg::REG_CURRENT_V_OFFSET, 16'h0000);
    wr(rmsaux_pkg::REG_CURRENT_V_GAIN, 16'h0000);
    samp(16'h0000, 16'h0005, 16'h0000);
    wr(rmsaux_pkg::REG_DSP_CONFIG, 16'h0040);
    rd(rmsaux_pkg::REG_DSP_CONFIG, 16'h0040);
    repeat (20) @(posedge clk);
    #1;
    hi = 0;
    rises = 0;
    last = aux_out;
    repeat (64) begin
      @(posedge clk);
      #1;
      hi += int'(aux_out === 1'b1);
      rises += int'(aux_out === 1'b1 && last === 1'b0);
      last = aux_out;
    end
    check(hi, 20, "pwm high time");
    check(rises, 4, "pwm period");
    // clearing the select drops back to a low gap before the next frame
    wr(rmsaux_pkg::REG_DSP_CONFIG, 16'h0000);
    hi = 0;
    repeat (64) begin
      @(posedge clk);
      #1;
      hi += int'(aux_out !== 1'b0);
    end
    check(hi, 0, "gap after pwm");
    // mid-run reset with pwm selected: select and pin back to serial defaults
    wr(rmsaux_pkg::REG_DSP_CONFIG, 16'h0040);
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check({31'h0, aux_out}, 32'h0, "pin after reset");
    rd(rmsaux_pkg::REG_DSP_CONFIG, rmsaux_pkg::CONFIG_RESET);
    wrap_up;
  end
endmodule // tb_rms_current_aux_output
